// [src/tcs_clock_prescaler.v]
// clock-source selection, prescaler and 16-bit up counter of a general timer
// assumes one clock (timer clock), synchronous active-low reset, pins asynchronous
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "tcs_defines.vh"

module tcs_clock_prescaler
#(
  parameter FLT_MAX = 4'hf
)
(
  input wire clk,
  input wire rst_n,
  input wire [`TCS_ADDR_W-1:0] addr,
  input wire [31:0] wrData,
  input wire wrStb,
  input wire rdStb,
  output reg [31:0] rdData,
  input wire [1:0] channelInputPins,
  input wire [3:0] internalTriggerInputs,
  input wire externalTriggerInput,
  output wire prescaledCountClock,
  output wire updateEvent,
  output reg [15:0] counter
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg counterRunBit;
  reg [2:0] slaveModeSelect;
  reg [2:0] triggerSourceSelect;
  reg extClockMode1Bit;
  reg [3:0] etiFilter;
  reg [15:0] prescaleValue;
  reg [15:0] reloadValue;
  reg [15:0] activePrescale;
  reg [15:0] activeReload;
  reg [15:0] prescaleCount;
  reg [1:0] chPolarity;
  wire updateGen;

  assign updateGen = wrStb && (addr == `TCS_OFF_EVG) && wrData[`TCS_EVG_UPG];

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      counterRunBit <= 1'b0;
      slaveModeSelect <= 3'h0;
      triggerSourceSelect <= 3'h0;
      extClockMode1Bit <= 1'b0;
      etiFilter <= 4'h0;
      chPolarity <= 2'h0;
      prescaleValue <= `TCS_RST_PSC;
      reloadValue <= `TCS_RST_CAR;
    end
    else if (wrStb)
    begin
      case (addr)
        `TCS_OFF_CTRL:
        begin
          counterRunBit <= wrData[`TCS_CTRL_RUN];
          chPolarity <= wrData[`TCS_CTRL_POL_LSB+:2];
        end
        `TCS_OFF_SMCFG:
        begin
          slaveModeSelect <= wrData[`TCS_SMCFG_SMS_LSB+:3];
          triggerSourceSelect <= wrData[`TCS_SMCFG_TSS_LSB+:3];
          extClockMode1Bit <= wrData[`TCS_SMCFG_ECM1];
          etiFilter <= wrData[`TCS_SMCFG_FLT_LSB+:4];
        end
        // prescale and reload land in buffer copies only
        `TCS_OFF_PSC: prescaleValue <= wrData[15:0];
        `TCS_OFF_CAR: reloadValue <= wrData[15:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [6:0] syncA;
  reg [6:0] syncB;
  reg [6:0] syncC;
  reg [6:0] stable;
  wire [6:0] rawIn;
  assign rawIn = {externalTriggerInput, internalTriggerInputs, channelInputPins};

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      syncA <= 7'h00;
      syncB <= 7'h00;
      syncC <= 7'h00;
      stable <= 7'h00;
    end
    else
    begin
      syncA <= rawIn;
      syncB <= syncA;
      syncC <= syncB;
      // a new level counts once the last two stages agree
      stable <= (syncB & syncC) | (stable & (syncB | syncC));
    end
  end

  // ---------------------------------------------------------------
  // external trigger sampling filter
  // ---------------------------------------------------------------
  reg [3:0] fltCount;
  reg etiFiltered;
  reg etiPrev;
  reg [5:0] srcPrev;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      fltCount <= 4'h0;
      etiFiltered <= 1'b0;
    end
    else if (stable[6] == etiFiltered)
      fltCount <= 4'h0;
    // a change must hold for filter length plus one cycles
    else if (fltCount >= etiFilter || fltCount == FLT_MAX)
    begin
      etiFiltered <= stable[6];
      fltCount <= 4'h0;
    end
    else
      fltCount <= fltCount + 4'h1;
  end

  // ---------------------------------------------------------------
  // edge detectors
  // ---------------------------------------------------------------
  // previous levels reset to the idle low level, so no false edge after reset
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      etiPrev <= 1'b0;
      srcPrev <= 6'h00;
    end
    else
    begin
      etiPrev <= etiFiltered;
      srcPrev <= stable[5:0];
    end
  end

  wire etiRise;
  wire [3:0] itiRise;
  wire ci0Any;
  wire [1:0] ciPol;
  assign etiRise = etiFiltered & ~etiPrev;
  assign itiRise = stable[5:2] & ~srcPrev[5:2];
  assign ci0Any = stable[0] ^ srcPrev[0];
  // polarity 0 rising, 1 falling
  assign ciPol = (stable[1:0] ^ chPolarity) & ~(srcPrev[1:0] ^ chPolarity);

  // ---------------------------------------------------------------
  // trigger source decode
  // ---------------------------------------------------------------
  reg trgTick;
  wire modeExtClk0;
  wire modeTrigger;
  wire modeInternal;

  // slave modes 1 to 3 follow the same trigger clock path as mode 7
  assign modeExtClk0 = (slaveModeSelect == `TCS_SMS_EXTCLK0);
  assign modeTrigger = (slaveModeSelect >= `TCS_SMS_TRIG_LO) && (slaveModeSelect <= `TCS_SMS_TRIG_HI);
  assign modeInternal = !modeExtClk0 && !modeTrigger;

  // source 4 counts both edges of channel 0
  always @*
  begin
    trgTick = 1'b0;
    case (triggerSourceSelect)
      `TCS_TSS_CI0_EDGE: trgTick = ci0Any;
      `TCS_TSS_CI0_FILT: trgTick = ciPol[0];
      `TCS_TSS_CI1_FILT: trgTick = ciPol[1];
      `TCS_TSS_ETI: trgTick = etiRise;
      default: trgTick = itiRise[triggerSourceSelect[1:0]];
    endcase
  end

  // ---------------------------------------------------------------
  // clock source selection
  // ---------------------------------------------------------------
  reg srcTick;

  // external clock mode 1 overrides the slave mode
  always @*
  begin
    srcTick = 1'b1;
    if (extClockMode1Bit)
      srcTick = etiRise;
    else if (modeInternal)
      srcTick = 1'b1;
    else
      srcTick = trgTick;
  end

  // ---------------------------------------------------------------
  // counting clock and update event
  // ---------------------------------------------------------------
  wire overflow;
  wire divEnd;

  // the divider ends its cycle when its count meets the active value
  assign divEnd = (prescaleCount == activePrescale);
  assign prescaledCountClock = counterRunBit && srcTick && divEnd;
  assign overflow = prescaledCountClock && (counter == activeReload);
  assign updateEvent = overflow || updateGen;

  // ---------------------------------------------------------------
  // prescaler and active copies
  // ---------------------------------------------------------------
  // an update restarts the divider so a new factor starts from zero
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      prescaleCount <= 16'h0000;
      activePrescale <= `TCS_RST_PSC;
      activeReload <= `TCS_RST_CAR;
    end
    else if (updateEvent)
    begin
      activePrescale <= prescaleValue;
      activeReload <= reloadValue;
      prescaleCount <= 16'h0000;
    end
    else if (counterRunBit && srcTick)
    begin
      if (divEnd)
        prescaleCount <= 16'h0000;
      else
        prescaleCount <= prescaleCount + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // software update and overflow both restart from zero
  always @(posedge clk)
  begin
    if (!rst_n)
      counter <= 16'h0000;
    else if (updateEvent)
      counter <= 16'h0000;
    else if (prescaledCountClock)
      counter <= counter + 16'h0001;
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
      rdData <= 32'h00000000;
    else if (rdStb)
    begin
      case (addr)
        `TCS_OFF_CTRL: rdData <= {29'h0, chPolarity, counterRunBit};
        `TCS_OFF_SMCFG: rdData <= {17'h0, extClockMode1Bit, 2'h0, etiFilter, 1'b0, triggerSourceSelect,
                                   1'b0, slaveModeSelect};
        `TCS_OFF_PSC: rdData <= {16'h0, prescaleValue};
        `TCS_OFF_CAR: rdData <= {16'h0, reloadValue};
        `TCS_OFF_CNT: rdData <= {16'h0, counter};
        `TCS_OFF_STAT: rdData <= {16'h0, activePrescale};
        // write-only and unmapped indices read as zero
        default: rdData <= 32'h00000000;
      endcase
    end
    else
      rdData <= 32'h00000000;
  end

endmodule

// [src/tcs_defines.vh]
// register offsets, field positions and reset values of the clock-source prescaler
// assumes inclusion by bare name from design files
`ifndef TCS_DEFINES_VH
`define TCS_DEFINES_VH

`define TCS_ADDR_W 4
`define TCS_OFF_CTRL 4'h0
`define TCS_OFF_SMCFG 4'h1
`define TCS_OFF_PSC 4'h2
`define TCS_OFF_CAR 4'h3
`define TCS_OFF_CNT 4'h4
`define TCS_OFF_EVG 4'h5
`define TCS_OFF_STAT 4'h6

`define TCS_CTRL_RUN 0
`define TCS_CTRL_POL_LSB 1
`define TCS_SMCFG_SMS_LSB 0
`define TCS_SMCFG_TSS_LSB 4
`define TCS_SMCFG_ECM1 14
`define TCS_SMCFG_FLT_LSB 8
`define TCS_EVG_UPG 0

`define TCS_SMS_INTERNAL 3'h0
`define TCS_SMS_EXTCLK0 3'h7
`define TCS_TSS_CI0_EDGE 3'h4
`define TCS_TSS_CI0_FILT 3'h5
`define TCS_TSS_CI1_FILT 3'h6
`define TCS_TSS_ETI 3'h7
`define TCS_SMS_TRIG_LO 3'h1
`define TCS_SMS_TRIG_HI 3'h3

`define TCS_RST_PSC 16'h0000
`define TCS_RST_CAR 16'hffff

`endif

// [testbench/tcs_pin_model.sv]
// far side: pulse trains on trigger, channel and external pins
// assumes start is one cycle with pick and nPulses steady
`timescale 1ns/10ps
module tcs_pin_model(
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [2:0] pick,
  input wire [7:0] nPulses,
  output wire busy,
  output wire [7:0] pins
);
  reg [7:0] left;
  reg [2:0] phase;
  reg lvl;
  // idle pins sit low; bit order iti0..3, ch0, ch1, ext
  assign pins = lvl ? 8'h1 << pick : 8'h0;
  assign busy = left != 8'h0;
  always @(posedge clk)
  begin
    if (!rst_n || start)
      {left, phase, lvl} <= {rst_n ? nPulses : 8'h0, 3'h0, 1'b0};
    else if (busy)
    begin
      phase <= phase == 3'h5 ? 3'h0 : phase + 3'h1;
      if (phase == 3'h5)
        lvl <= !lvl;
      if (phase == 3'h5 && lvl)
        left <= left - 8'h1;
    end
  end
endmodule

// [testbench/tcs_props.sv]
// assertions on the prescaler ports
// assumes bind into every tcs_clock_prescaler
`timescale 1ns/10ps
module tcs_props(
  input wire clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [31:0] wrData,
  input wire wrStb,
  input wire rdStb,
  input wire [31:0] rdData,
  input wire prescaledCountClock,
  input wire updateEvent,
  input wire [15:0] counter
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  reg run;
  reg [15:0] prescale_value, pa, car, ca;
  reg [14:0] cfg;
  wire intSel = !cfg[14] && (cfg[2:0] == 3'h0 || (cfg[2] && cfg[2:0] != 3'h7));
  // shadow copies of the registers
  always @(posedge clk)
  begin
    if (!rst_n)
      {run, prescale_value, pa, car, ca, cfg} <= {1'b0, 32'h0, 32'hffffffff, 15'h0};
    else
    begin
      if (wrStb && addr == 4'h0)
        run <= wrData[0];
      if (wrStb && addr == 4'h1)
        cfg <= wrData[14:0];
      if (wrStb && addr == 4'h2)
        prescale_value <= wrData[15:0];
      if (wrStb && addr == 4'h3)
        car <= wrData[15:0];
      if (updateEvent)
        {pa, ca} <= {prescale_value, car};
    end
  end
  sequence upgWr;
    wrStb && addr == 4'h5 && wrData[0];
  endsequence
  upg_pulse_a: assert property (upgWr |-> updateEvent)
    else $error("no update");
  upd_clear_a: assert property (updateEvent |=> counter == 16'h0)
    else $error("no clear");
  adv_step_a: assert property (prescaledCountClock && !updateEvent |=> counter == $past(counter) + 16'h1)
    else $error("bad step");
  cnt_hold_a: assert property ($changed(counter) |-> $past(prescaledCountClock) || $past(updateEvent))
    else $error("stray count");
  run_gate_a: assert property (!run |-> !prescaledCountClock)
    else $error("count while stopped");
  wrap_update_a: assert property (prescaledCountClock && counter == ca |-> updateEvent)
    else $error("no overflow update");
  int_tick_a: assert property ((run && intSel && pa == 16'h0)[*2] |-> prescaledCountClock)
    else $error("internal clock lost");
  psc_read_a: assert property (rdStb && addr == 4'h6 |=> rdData[15:0] == $past(pa))
    else $error("active prescale wrong");
endmodule
bind tcs_clock_prescaler tcs_props chk(.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
  .rdStb(rdStb), .rdData(rdData), .prescaledCountClock(prescaledCountClock), .updateEvent(updateEvent),
  .counter(counter));

// [testbench/timer_clock_source_prescaler_tb_top.sv]
// random and corner tests of the clock-source prescaler
// assumes checker and pin model compiled first
`timescale 1ns/10ps
module timer_clock_source_prescaler_tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wrData = 32'h0;
  reg wrStb = 1'b0;
  reg rdStb = 1'b0;
  reg start = 1'b0;
  reg [2:0] pick = 3'h7;
  reg [7:0] nPulses = 8'h0;
  reg [15:0] seed = 16'ha9f7;
  wire [31:0] rdData;
  wire [7:0] pins;
  wire busy;
  integer bad_count = 0;
  integer checked = 0;
  integer k, i, n, c, r, p;
  always #5 clk = !clk;
  tcs_clock_prescaler dut(.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .channelInputPins(pins[5:4]), .internalTriggerInputs(pins[3:0]),
    .externalTriggerInput(pins[6]), .prescaledCountClock(), .updateEvent(), .counter());
  tcs_pin_model far(.clk(clk), .rst_n(rst_n), .start(start), .pick(pick), .nPulses(nPulses), .busy(busy),
    .pins(pins));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [31:0] expCnt(input integer ticks, input integer div, input integer lim);
    expCnt = (ticks / div) % lim;
  endfunction
  task test_done;
    begin
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task acc(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      {addr, wrData, wrStb, rdStb} <= {a, d, w, !w};
      @(posedge clk);
      {wrStb, rdStb} <= 2'b00;
      #1;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        $display("MISMATCH rdData at index %h expected %h seen %h", addr, exp, seen);
        bad_count = bad_count + 1;
      end
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      acc(1'b0, a, 32'h0);
      check(rdData, e);
    end
  endtask
  initial
  begin
    p = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h3, 32'hffff);
    rd(4'h7, 32'h0);
    // internal clock: modes 0, 4, 5, 6 with random divide and reload
    for (k = 0; k < 8; k = k + 1)
    begin
      seed = lfsr(seed);
      n = seed[1:0];
      c = seed[4:2] + 2;
      r = seed[9:5] + 8;
      acc(1'b1, 4'h1, k % 4 == 0 ? 0 : 3 + k % 4);
      acc(1'b1, 4'h2, n);
      acc(1'b1, 4'h3, c);
      rd(4'h6, p);
      acc(1'b1, 4'h5, 32'h1);
      rd(4'h6, n);
      p = n;
      acc(1'b1, 4'h0, 32'h1);
      repeat (r) @(posedge clk);
      acc(1'b1, 4'h0, 32'h0);
      rd(4'h4, expCnt(r + 2, n + 1, c + 1));
      $display("internal test %0d done", k);
    end
    acc(1'b1, 4'h2, 32'h0);
    acc(1'b1, 4'h3, 32'hffff);
    // edge sources: triggers, channel pins, external pin, mode 1
    begin : edgeTests
      for (k = 0; k < 10; k = k + 1)
      begin
        seed = lfsr(seed);
        // test 8 lengthens the external filter, test 6 counts falling edges of channel 1
        acc(1'b1, 4'h1, k == 8 ? 32'h4300 : k == 9 ? 32'h1 : {k[2:0], 4'h7});
        acc(1'b1, 4'h5, 32'h1);
        acc(1'b1, 4'h0, k == 6 ? 32'h5 : 32'h1);
        @(posedge clk);
        nPulses <= seed[2:0] + 8'h1;
        pick <= k < 4 ? k : k < 6 ? 4 : k == 6 ? 5 : k == 9 ? 0 : 6;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
        for (i = 0; i < 500 && busy; i = i + 1)
          #10;
        if (busy)
        begin
          bad_count = bad_count + 1;
          disable edgeTests;
        end
        repeat (30) @(posedge clk);
        acc(1'b1, 4'h0, 32'h0);
        rd(4'h4, (seed[2:0] + 1) * (k == 4 ? 2 : 1));
        $display("edge test %0d done", k);
      end
    end
    test_done;
  end
endmodule
